// ---- dv/serb_fabric_model.sv ----
// fabric-side model: the two block clock ticks that surrounding logic drives
// assumes one system clock; block clock 1 runs at half the rate of block clock 0
`timescale 1ns/100ps
`default_nettype none
module serb_fabric_model (
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   output logic o_clk0_tick,
   output logic o_clk1_tick
);
   // ****************************************************************
   // tick generation
   // ****************************************************************
   logic half_ff;
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         half_ff <= 1'b0;
      end else begin
         half_ff <= ~half_ff;
      end
   end
   // clock 0 ticks every cycle so a write path on clock 0 never waits
   assign o_clk0_tick = 1'b1;
   assign o_clk1_tick = half_ff;
endmodule
`default_nettype wire

// ---- dv/serb_top_assertions.sv ----
// checker for the embedded ram / shift block, watching top-level ports only
// assumes the register bus is the only path by which the configuration changes
`timescale 1ns/100ps
`default_nettype none
module serb_top_chk
   import serb_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   input wire logic [3:0] i_reg_addr,
   input wire logic [31:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [31:0] o_reg_rdata,
   input wire logic i_clk0_tick,
   input wire logic i_clk1_tick,
   input wire logic i_out_clr,
   input wire logic [WORD_W-1:0] o_q,
   input wire logic o_cfg_err
);
   // ****************************************************************
   // shadow of the configuration registers
   // ****************************************************************
   logic [31:0] cfg_ff;
   logic [31:0] shf_ff;
   wire logic [31:0] nxt_cfg = (i_reg_wr && i_reg_addr == REG_CFG) ? i_reg_wdata & CFG_MASK
      : cfg_ff;
   wire logic [31:0] nxt_shf = (i_reg_wr && i_reg_addr == REG_SHIFT) ? i_reg_wdata & SHIFT_MASK
                                                                     : shf_ff;
   wire logic [9:0] tap_bits = 10'(shf_ff[20:16]) * 10'(shf_ff[4:0]);
   wire logic [15:0] tot_bits = 16'(shf_ff[4:0]) * 16'(shf_ff[13:8]) * 16'(shf_ff[20:16]);
   wire logic is_shift = (cfg_ff[2:0] == 3'h4);
   wire logic nz = (shf_ff[4:0] != 5'h0) && (shf_ff[13:8] != 6'h0) && (shf_ff[20:16] != 5'h0);
   wire logic out_tick = cfg_ff[CFG_OCLK_BIT] ? i_clk1_tick : i_clk0_tick;
   wire logic mapped = i_reg_addr inside {REG_CFG, REG_SHIFT, REG_STAT};
   wire logic regd = !cfg_ff[CFG_BYPASS_BIT];
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cfg_ff <= CFG_RST;
         shf_ff <= SHIFT_RST;
      end else begin
         cfg_ff <= nxt_cfg;
         shf_ff <= nxt_shf;
      end
   end
   // ****************************************************************
   // properties
   // ****************************************************************
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_b);
   property p_rd_idle; !i_reg_rd |=> o_reg_rdata == 32'h0; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
   property p_unmapped; i_reg_rd && !mapped |=> o_reg_rdata == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_cfg_rd; i_reg_rd && i_reg_addr == REG_CFG |=> o_reg_rdata == $past(cfg_ff);
   endproperty
   a_cfg_rd: assert property (p_cfg_rd) else $error("config readback wrong");
   property p_shf_rd; i_reg_rd && i_reg_addr == REG_SHIFT |=> o_reg_rdata == $past(shf_ff);
   endproperty
   a_shf_rd: assert property (p_shf_rd) else $error("shift readback wrong");
   property p_stat; i_reg_rd && i_reg_addr == REG_STAT |=> o_reg_rdata[0] == $past(o_cfg_err);
   endproperty
   a_stat: assert property (p_stat) else $error("status error bit wrong");
   property p_err_mode; cfg_ff[2:0] > 3'h4 |-> o_cfg_err; endproperty
   a_err_mode: assert property (p_err_mode) else $error("bad mode accepted");
   property p_err_taps; is_shift && tap_bits >= SR_MAX_TAP_BITS |-> o_cfg_err; endproperty
   a_err_taps: assert property (p_err_taps) else $error("too many tap bits accepted");
   property p_err_size; is_shift && tot_bits > SR_MAX_BITS |-> o_cfg_err; endproperty
   a_err_size: assert property (p_err_size) else $error("oversize shift accepted");
   property p_legal;
      is_shift && cfg_ff[10:4] == 7'h0 && nz && tap_bits < SR_MAX_TAP_BITS
         && tot_bits <= SR_MAX_BITS |-> !o_cfg_err;
   endproperty
   a_legal: assert property (p_legal) else $error("legal shift refused");
   property p_out_clr; i_out_clr && regd && !i_reg_wr |=> o_q == '0; endproperty
   a_out_clr: assert property (p_out_clr) else $error("output clear ignored");
   property p_out_tick;
      regd && $past(regd) && !$past(i_reg_wr) && !$past(i_out_clr) && $changed(o_q)
         |-> $past(out_tick);
   endproperty
   a_out_tick: assert property (p_out_tick) else $error("output moved off its tick");
endmodule
bind serb_top serb_top_chk u_chk (
   .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
   .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
   .i_clk0_tick(i_clk0_tick), .i_clk1_tick(i_clk1_tick), .i_out_clr(i_out_clr), .o_q(o_q),
   .o_cfg_err(o_cfg_err));
`default_nettype wire

// ---- dv/tb_serb_top.sv ----
// self-checking bench for the embedded ram / shift block
// assumes the fabric model supplies both block clock ticks
`timescale 1ns/100ps
`default_nettype none
module tb_serb_top;
   import serb_pkg::*;
   // ****************************************************************
   // signals, helpers and bus tasks
   // ****************************************************************
   localparam logic [MEM_BITS-1:0] IMG = {16{36'hA_BCDE_1234}};
   localparam logic [31:0] SH_TAB [7] = '{32'h0001_0101, 32'h0003_0106, 32'h0011_3F01,
      32'h0002_0204, 32'h0011_2001, 32'h0010_2401, 32'h0010_2501};
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic out_clr = 1'b0;
   logic wren = 1'b0;
   logic rden = 1'b0;
   logic [8:0] wr_addr = 9'h0;
   logic [8:0] rd_addr = 9'h0;
   logic [17:0] wr_data = 18'h0;
   wire logic [31:0] reg_rdata;
   wire logic [17:0] q;
   wire logic [17:0] cascade;
   wire logic cfg_err;
   wire logic tick0;
   wire logic tick1;
   logic [31:0] rs = 32'h13;
   logic [31:0] rv;
   logic [17:0] d;
   logic [3:0] s [8];
   int failures = 0;
   int n_checks = 0;
   int cycles = 0;
   always #5 clk = ~clk;
   serb_fabric_model u_fab (.i_sys_clk(clk), .i_rst_b(rst_b), .o_clk0_tick(tick0),
      .o_clk1_tick(tick1));
   serb_top #(.INIT_IMAGE(IMG)) uut (
      .i_sys_clk(clk), .i_rst_b(rst_b), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
      .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata), .i_clk0_tick(tick0),
      .i_clk1_tick(tick1), .i_in_clr(out_clr), .i_out_clr(out_clr), .i_wren(wren),
      .i_wr_addr(wr_addr), .i_wr_data(wr_data), .i_rden(rden), .i_rd_addr(rd_addr),
      .o_q(q), .o_cascade(cascade), .o_cfg_err(cfg_err));
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] t;
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   function automatic logic exp_err(input logic [2:0] md, input logic [31:0] sh);
      logic [15:0] tot;
      logic [15:0] taps;
      tot = 16'(sh[4:0]) * 16'(sh[13:8]) * 16'(sh[20:16]);
      taps = 16'(sh[4:0]) * 16'(sh[20:16]);
      return (md > 3'h4) || (md == 3'h4 && (tot == 16'h0 || tot > 16'h0240 || taps >= 16'h0012));
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      if (failures == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic reg_wr_t(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_rd_t(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
   endtask
   // one cycle on the memory ports; single-port mode reads through the write address
   task automatic cyc(input logic we, input logic re, input logic [8:0] a, input logic [17:0] v);
      @(posedge clk);
      wren <= we;
      rden <= re;
      wr_addr <= a;
      rd_addr <= a;
      wr_data <= v;
      @(posedge clk);
      wren <= 1'b0;
      rden <= 1'b0;
   endtask
   // enough edges for the slower output tick to load the result
   task automatic settle(output logic [17:0] v);
      repeat (4) @(posedge clk);
      #1;
      v = q;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         complete_run();
      end
   end
   // ****************************************************************
   // scenarios
   // ****************************************************************
   initial begin
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      reg_rd_t(REG_CFG, rv);
      chk(rv, CFG_RST);
      reg_rd_t(REG_SHIFT, rv);
      chk(rv, SHIFT_RST);
      reg_wr_t(4'hC, 32'hFFFF_FFFF);
      reg_rd_t(4'hC, rv);
      chk(rv, 32'h0);
      reg_wr_t(REG_CFG, 32'hFFFF_FFFF);
      reg_rd_t(REG_CFG, rv);
      chk(rv, CFG_MASK);
      reg_wr_t(REG_CFG, 32'h0000_0663);
      for (int i = 0; i < 2; i++) begin
         cyc(1'b1, 1'b0, 9'(i * 7), ~IMG[i * 126 +: 18]);
         cyc(1'b0, 1'b1, 9'(i * 7), 18'h0);
         settle(d);
         chk(32'(d), 32'(IMG[i * 126 +: 18]));
      end
      for (int i = 0; i < 9; i++) begin
         rs = xs(rs);
         reg_wr_t(REG_CFG, 32'h0000_0660 | 32'(i % 3) |
            {12'h0, rs[20], 1'b0, rs[22], 4'h0, rs[21], 12'h0});
         cyc(1'b1, 1'b0, {4'h0, rs[4:0]}, rs[30:13]);
         cyc(1'b0, 1'b1, {4'h0, rs[4:0]}, 18'h0);
         settle(d);
         chk(32'(d), 32'(rs[30:13]));
      end
      reg_wr_t(REG_CFG, 32'h0000_0660);
      @(posedge clk);
      out_clr <= 1'b1;
      @(posedge clk);
      out_clr <= 1'b0;
      #1;
      chk(32'(q), 32'h0);
      for (int k = 0; k < 2; k++) begin
         reg_wr_t(REG_CFG, 32'h0000_0660 | {18'h0, k[0], 13'h0});
         cyc(1'b1, 1'b0, 9'h005, 18'h2_5A5A);
         cyc(1'b1, 1'b1, 9'h005, 18'h1_C3C3);
         settle(d);
         chk(32'(d), (k == 1) ? 32'h0 : 32'h0002_5A5A);
      end
      reg_wr_t(REG_CFG, 32'h0000_0400);
      rs = xs(rs);
      for (int i = 0; i < 16; i++) begin
         cyc(1'b1, 1'b0, {5'h03, 4'(i)}, {17'h0, rs[i]});
      end
      cyc(1'b0, 1'b1, 9'h003, 18'h0);
      settle(d);
      chk(32'(d[15:0]), 32'(rs[15:0]));
      reg_wr_t(REG_SHIFT, 32'h0002_0204);
      reg_wr_t(REG_CFG, 32'h0000_0004);
      for (int j = 0; j < 8; j++) begin
         rs = xs(rs);
         s[j] = rs[3:0];
         @(posedge clk);
         wren <= 1'b1;
         wr_data <= {14'h0, rs[3:0]};
      end
      @(posedge clk);
      wren <= 1'b0;
      settle(d);
      chk(32'(d[7:0]), {24'h0, s[3], s[5]});
      chk(32'(cascade[3:0]), 32'(s[3]));
      for (int i = 0; i < 7; i++) begin
         reg_wr_t(REG_SHIFT, SH_TAB[i]);
         reg_wr_t(REG_CFG, (i == 0) ? 32'h0000_0005 : 32'h0000_0004);
         #1;
         chk(32'(cfg_err), 32'(exp_err((i == 0) ? 3'h5 : 3'h4, SH_TAB[i])));
         reg_rd_t(REG_STAT, rv);
         chk(32'(rv[0]), 32'(exp_err((i == 0) ? 3'h5 : 3'h4, SH_TAB[i])));
      end
      complete_run();
   end
endmodule
`default_nettype wire

// ---- rtl/serb_mem.sv ----
// 32 x 18 storage array, parity lanes included, written and read on the falling edge
// assumes the controller holds strobes, words and data stable for a whole cycle
`timescale 1ns/100ps
`default_nettype none
module serb_mem
   import serb_pkg::*;
#(
   parameter logic [MEM_BITS-1:0] INIT_IMAGE = '0
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   serb_mem_if.mem bus
);

   // ****************************************************************
   // array and next word
   // ****************************************************************
   logic [WORD_W-1:0] arr [DEPTH_WORDS];
   logic [WORD_W-1:0] rd_q_ff;
   logic [KEY_W-1:0] key_ff;
   wire logic [WORD_W-1:0] old_word;
   wire logic [WORD_W-1:0] shift_word;
   wire logic [WORD_W-1:0] merge_word;
   wire logic [WORD_W-1:0] nxt_word;

   assign old_word = arr[bus.wr_word];
   // every lane moves one tap further, the low shift_w lanes take the new sample
   assign shift_word = ((old_word << bus.shift_w) | bus.wr_data) & bus.shift_mask;
   assign merge_word = (old_word & ~bus.wr_mask) | (bus.wr_data & bus.wr_mask);
   assign nxt_word = bus.shift_en ? shift_word : merge_word;

   // preload image, used by ram and rom alike
   initial begin
      for (int i = 0; i < DEPTH_WORDS; i++) begin
         arr[i] = INIT_IMAGE[i*WORD_W +: WORD_W];
      end
   end

   // self-timed write on the falling edge after the inputs were registered
   always @(negedge i_sys_clk) begin
      if (bus.wr_stb) begin
         arr[bus.wr_word] <= nxt_word;
      end
   end

   // read samples the word before the same-edge write lands, so it sees old data
   always_ff @(negedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rd_q_ff <= '0;
         key_ff <= '0;
      end else if (bus.rd_stb) begin
         rd_q_ff <= bus.rd_blank ? '0 : arr[bus.rd_word];
         key_ff <= bus.rd_key;
      end
   end

   assign bus.rd_data = rd_q_ff;
   assign bus.rd_key_q = key_ff;

endmodule
`default_nettype wire

// ---- rtl/serb_mem_if.sv ----
// carrier between the block control and its storage array
// assumes both ends sit on the same system clock
`timescale 1ns/100ps
`default_nettype none
interface serb_mem_if;
   import serb_pkg::*;
   logic wr_stb;
   logic [WRD_AW-1:0] wr_word;
   logic [WORD_W-1:0] wr_mask;
   logic [WORD_W-1:0] wr_data;
   logic shift_en;
   logic [4:0] shift_w;
   logic [WORD_W-1:0] shift_mask;
   logic rd_stb;
   logic rd_blank;
   logic [WRD_AW-1:0] rd_word;
   logic [KEY_W-1:0] rd_key;
   logic [KEY_W-1:0] rd_key_q;
   logic [WORD_W-1:0] rd_data;
   modport ctl (output wr_stb, wr_word, wr_mask, wr_data, shift_en, shift_w, shift_mask,
                output rd_stb, rd_blank, rd_word, rd_key, input rd_key_q, rd_data);
   modport mem (input wr_stb, wr_word, wr_mask, wr_data, shift_en, shift_w, shift_mask,
                input rd_stb, rd_blank, rd_word, rd_key, output rd_key_q, rd_data);
endinterface
`default_nettype wire

// ---- rtl/serb_pkg.sv ----
// constants, field layouts and enumerations of the small embedded ram / shift block
// assumes one system clock; the two block clocks arrive as same-domain tick strobes
package serb_pkg;

   // ****************************************************************
   // storage geometry
   // ****************************************************************
   localparam int unsigned MEM_BITS = 576;
   localparam int unsigned DEPTH_WORDS = 32;
   localparam int unsigned WORD_W = 18;
   localparam int unsigned ADDR_W = 9;
   localparam int unsigned WRD_AW = 5;
   localparam int unsigned KEY_W = 12;
   localparam logic [15:0] SR_MAX_BITS = 16'h0240;
   localparam logic [9:0] SR_MAX_TAP_BITS = 10'h012;

   // ****************************************************************
   // register map and fields
   // ****************************************************************
   localparam logic [3:0] REG_CFG = 4'h0;
   localparam logic [3:0] REG_SHIFT = 4'h4;
   localparam logic [3:0] REG_STAT = 4'h8;
   localparam logic [31:0] CFG_MASK = 32'h000F_3777;
   localparam logic [31:0] SHIFT_MASK = 32'h001F_3F1F;
   localparam logic [31:0] CFG_RST = 32'h0000_0000;
   localparam logic [31:0] SHIFT_RST = 32'h0001_0101;
   localparam int unsigned CFG_MODE_LSB = 0;
   localparam int unsigned CFG_WSHAPE_LSB = 4;
   localparam int unsigned CFG_RSHAPE_LSB = 8;
   localparam int unsigned CFG_BYPASS_BIT = 12;
   localparam int unsigned CFG_RDW_DC_BIT = 13;
   localparam int unsigned CFG_WCLK_BIT = 16;
   localparam int unsigned CFG_RACLK_BIT = 17;
   localparam int unsigned CFG_RECLK_BIT = 18;
   localparam int unsigned CFG_OCLK_BIT = 19;
   localparam int unsigned SH_W_LSB = 0;
   localparam int unsigned SH_M_LSB = 8;
   localparam int unsigned SH_N_LSB = 16;
   localparam int unsigned STAT_ERR_BIT = 0;
   localparam int unsigned STAT_PTR_LSB = 8;

   // ****************************************************************
   // modes and shapes
   // ****************************************************************
   typedef enum logic [2:0] {
      SERB_SDP = 3'b000,
      SERB_SP = 3'b001,
      SERB_FIFO = 3'b010,
      SERB_ROM = 3'b011,
      SERB_SHIFT = 3'b100
   } serb_mode_e;

   typedef enum logic [2:0] {
      SERB_X1 = 3'b000,
      SERB_X2 = 3'b001,
      SERB_X4 = 3'b010,
      SERB_X8 = 3'b011,
      SERB_X16 = 3'b100,
      SERB_X9 = 3'b101,
      SERB_X18 = 3'b110
   } serb_shape_e;

endpackage

// ---- rtl/serb_top.sv ----
// small embedded ram / rom / shift block: 576 bits, mixed widths, configurable clocks
// assumes fabric logic on i_sys_clk drives ports and the two block clock ticks
//
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module serb_top
   import serb_pkg::*;
#(
   parameter logic [MEM_BITS-1:0] INIT_IMAGE = '0
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   input wire logic [3:0] i_reg_addr,
   input wire logic [31:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [31:0] o_reg_rdata,
   input wire logic i_clk0_tick,
   input wire logic i_clk1_tick,
   input wire logic i_in_clr,
   input wire logic i_out_clr,
   input wire logic i_wren,
   input wire logic [ADDR_W-1:0] i_wr_addr,
   input wire logic [WORD_W-1:0] i_wr_data,
   input wire logic i_rden,
   input wire logic [ADDR_W-1:0] i_rd_addr,
   output logic [WORD_W-1:0] o_q,
   output logic [WORD_W-1:0] o_cascade,
   output logic o_cfg_err
);

   // ****************************************************************
   // shape helpers
   // ****************************************************************
   function automatic logic [4:0] shape_w(input serb_shape_e s);
      unique case (s)
         SERB_X1: return 5'h01;
         SERB_X2: return 5'h02;
         SERB_X4: return 5'h04;
         SERB_X8: return 5'h08;
         SERB_X16: return 5'h10;
         SERB_X9: return 5'h09;
         SERB_X18: return 5'h12;
         default: return 5'h01;
      endcase
   endfunction

   // narrow shapes pack densely over the 16 data lanes of each word
   function automatic logic [8:0] bit_idx(input serb_shape_e s, input logic [8:0] a);
      logic [17:0] p;
      p = 18'(a) * 18'(shape_w(s));
      return p[8:0];
   endfunction

   function automatic logic [4:0] word_of(input serb_shape_e s, input logic [8:0] a);
      logic [8:0] b;
      b = bit_idx(s, a);
      if (s == SERB_X9) return a[5:1];
      if (s == SERB_X18) return a[4:0];
      return b[8:4];
   endfunction

   function automatic logic [3:0] off_of(input serb_shape_e s, input logic [8:0] a);
      logic [8:0] b;
      b = bit_idx(s, a);
      if (s == SERB_X9) return {a[0], 3'b000};
      if (s == SERB_X18) return 4'h0;
      return b[3:0];
   endfunction

   // parity shapes put bit 8 of each byte in lanes 16 and 17
   function automatic logic [17:0] mask_of(input serb_shape_e s, input logic [8:0] a);
      logic [3:0] o;
      o = off_of(s, a);
      if (s == SERB_X9) return (18'h000FF << o) | (18'h10000 << a[0]);
      if (s == SERB_X18) return 18'h3FFFF;
      return ((18'h00001 << shape_w(s)) - 18'h00001) << o;
   endfunction

   function automatic logic [17:0] place(input serb_shape_e s, input logic [8:0] a,
                                         input logic [17:0] d);
      logic [3:0] o;
      o = off_of(s, a);
      if (s == SERB_X9) return ({10'h000, d[7:0]} << o) | ({17'h00000, d[8]} << (16 + a[0]));
      if (s == SERB_X18) return d;
      return d << o;
   endfunction

   function automatic logic [17:0] extract(input logic [KEY_W-1:0] k, input logic [17:0] w);
      serb_shape_e s;
      logic [8:0] a;
      logic [3:0] o;
      s = serb_shape_e'(k[11:9]);
      a = k[8:0];
      o = off_of(s, a);
      if (s == SERB_X9) return {9'h000, w[16 + a[0]], w[o +: 8]};
      if (s == SERB_X18) return w;
      return (w >> o) & ((18'h00001 << shape_w(s)) - 18'h00001);
   endfunction

   // ****************************************************************
   // register bank
   // ****************************************************************
   logic [31:0] cfg_ff;
   logic [31:0] shift_ff;
   logic [31:0] rdata_ff;
   logic [WRD_AW-1:0] ptr_ff;
   wire logic wr_cfg;
   wire logic wr_shift;
   wire logic [31:0] nxt_rdata;

   assign wr_cfg = i_reg_wr && (i_reg_addr == REG_CFG);
   assign wr_shift = i_reg_wr && (i_reg_addr == REG_SHIFT);
   assign nxt_rdata = !i_reg_rd ? 32'h0000_0000 :
                      (i_reg_addr == REG_CFG) ? cfg_ff :
                      (i_reg_addr == REG_SHIFT) ? shift_ff :
                      (i_reg_addr == REG_STAT) ? ({31'h0, o_cfg_err} << STAT_ERR_BIT) |
                                                 ({27'h0, ptr_ff} << STAT_PTR_LSB) :
                      32'h0000_0000;

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cfg_ff <= CFG_RST;
         shift_ff <= SHIFT_RST;
         rdata_ff <= 32'h0000_0000;
      end else begin
         if (wr_cfg) cfg_ff <= i_reg_wdata & CFG_MASK;
         if (wr_shift) shift_ff <= i_reg_wdata & SHIFT_MASK;
         rdata_ff <= nxt_rdata;
      end
   end

   assign o_reg_rdata = rdata_ff;

   // ****************************************************************
   // configuration decode and legality
   // ****************************************************************
   wire serb_mode_e mode = serb_mode_e'(cfg_ff[CFG_MODE_LSB +: 3]);
   wire serb_shape_e wshape = serb_shape_e'(cfg_ff[CFG_WSHAPE_LSB +: 3]);
   wire serb_shape_e rshape = serb_shape_e'(cfg_ff[CFG_RSHAPE_LSB +: 3]);
   wire logic bypass = cfg_ff[CFG_BYPASS_BIT];
   wire logic rdw_dc = cfg_ff[CFG_RDW_DC_BIT];
   wire logic [4:0] sh_w = shift_ff[SH_W_LSB +: 5];
   wire logic [5:0] sh_m = shift_ff[SH_M_LSB +: 6];
   wire logic [4:0] sh_n = shift_ff[SH_N_LSB +: 5];
   wire logic is_shift = (mode == SERB_SHIFT);
   wire logic [9:0] tap_bits = 10'(sh_n) * 10'(sh_w);
   wire logic [15:0] sr_bits = 16'(tap_bits) * 16'(sh_m);
   wire logic sr_ok = (sr_bits <= SR_MAX_BITS) &&
                      (tap_bits < SR_MAX_TAP_BITS) &&
                      (sh_w != 5'h00) && (sh_m != 6'h00) && (sh_n != 5'h00);
   wire logic wpar = (wshape == SERB_X9) || (wshape == SERB_X18);
   wire logic rpar = (rshape == SERB_X9) || (rshape == SERB_X18);
   // parity shapes only pair with themselves; shape code 7 is not a shape
   wire logic shape_ok = (cfg_ff[CFG_WSHAPE_LSB +: 3] != 3'h7) &&
                         (cfg_ff[CFG_RSHAPE_LSB +: 3] != 3'h7) &&
                         (!(wpar || rpar) || (wshape == rshape));
   wire logic mode_ok = (cfg_ff[CFG_MODE_LSB +: 3] <= 3'h4);
   wire logic legal = mode_ok && (is_shift ? sr_ok : shape_ok);

   assign o_cfg_err = !legal;

   // ****************************************************************
   // clock selection per register group
   // ****************************************************************
   wire logic wr_tick = cfg_ff[CFG_WCLK_BIT] ? i_clk1_tick : i_clk0_tick;
   wire logic ra_tick = cfg_ff[CFG_RACLK_BIT] ? i_clk1_tick : i_clk0_tick;
   wire logic re_tick = cfg_ff[CFG_RECLK_BIT] ? i_clk1_tick : i_clk0_tick;
   wire logic out_tick = cfg_ff[CFG_OCLK_BIT] ? i_clk1_tick : i_clk0_tick;

   // ****************************************************************
   // input registers, never bypassed
   // ****************************************************************
   logic [ADDR_W-1:0] wa_ff;
   logic [WORD_W-1:0] wd_ff;
   logic wr_stb_ff;
   logic [ADDR_W-1:0] ra_ff;
   logic rd_stb_ff;
   // single-port mode reads through the write address port
   wire logic [ADDR_W-1:0] nxt_ra = (mode == SERB_SP) ? i_wr_addr : i_rd_addr;

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         wa_ff <= '0;
         wd_ff <= '0;
         wr_stb_ff <= 1'b0;
      end else if (i_in_clr) begin
         wa_ff <= '0;
         wd_ff <= '0;
         wr_stb_ff <= 1'b0;
      end else begin
         if (wr_tick) wa_ff <= i_wr_addr;
         if (wr_tick) wd_ff <= i_wr_data;
         wr_stb_ff <= wr_tick && i_wren;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ra_ff <= '0;
         rd_stb_ff <= 1'b0;
      end else if (i_in_clr) begin
         ra_ff <= '0;
         rd_stb_ff <= 1'b0;
      end else begin
         if (ra_tick) ra_ff <= nxt_ra;
         rd_stb_ff <= re_tick && i_rden;
      end
   end

   // ****************************************************************
   // shift pointer: one location per shift cycle, wraps at tap length for sh_m up to 32
   // ****************************************************************
   wire logic [WRD_AW-1:0] ptr_last = 5'(sh_m - 6'h01);
   wire logic [WRD_AW-1:0] nxt_ptr = (ptr_ff >= ptr_last) ? 5'h00 : 5'(ptr_ff + 5'h01);

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ptr_ff <= '0;
      end else if (i_in_clr || !is_shift) begin
         ptr_ff <= '0;
      end else if (wr_stb_ff && legal) begin
         ptr_ff <= nxt_ptr;
      end
   end

   // ****************************************************************
   // storage requests
   // ****************************************************************
   serb_mem_if mif ();

   wire logic [WORD_W-1:0] wmask = (18'h00001 << sh_w) - 18'h00001;
   wire logic do_wr = wr_stb_ff && legal && (mode != SERB_ROM);
   wire logic [WRD_AW-1:0] rd_word = word_of(rshape, ra_ff);
   wire logic [WRD_AW-1:0] wr_word = word_of(wshape, wa_ff);

   assign mif.wr_stb = do_wr;
   assign mif.wr_word = is_shift ? ptr_ff : wr_word;
   assign mif.wr_mask = mask_of(wshape, wa_ff);
   assign mif.wr_data = is_shift ? (wd_ff & wmask) : place(wshape, wa_ff, wd_ff);
   assign mif.shift_en = is_shift;
   assign mif.shift_w = sh_w;
   assign mif.shift_mask = (18'h00001 << tap_bits) - 18'h00001;
   // in shift mode the same location is read out before the new sample lands
   assign mif.rd_stb = is_shift ? do_wr : (rd_stb_ff && legal);
   assign mif.rd_word = is_shift ? ptr_ff : rd_word;
   assign mif.rd_key = {cfg_ff[CFG_RSHAPE_LSB +: 3], ra_ff};
   // blanking only where simple dual-port is asked for don't-care collisions
   assign mif.rd_blank = (mode == SERB_SDP) && rdw_dc && do_wr &&
                         (wr_word == rd_word);

   serb_mem #(
      .INIT_IMAGE(INIT_IMAGE)
   ) u_mem (
      .i_sys_clk(i_sys_clk),
      .i_rst_b(i_rst_b),
      .bus(mif.mem)
   );

   // ****************************************************************
   // read data path and output register
   // ****************************************************************
   logic [WORD_W-1:0] out_ff;
   logic [WORD_W-1:0] casc_ff;
   wire logic [9:0] last_sh = 10'(tap_bits - 10'(sh_w));
   wire logic [WORD_W-1:0] tap_word = mif.rd_data & mif.shift_mask;
   wire logic [WORD_W-1:0] casc_word = (mif.rd_data >> last_sh) & wmask;
   wire logic [WORD_W-1:0] rd_value = is_shift ? tap_word : extract(mif.rd_key_q, mif.rd_data);

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         out_ff <= '0;
         casc_ff <= '0;
      end else if (i_out_clr) begin
         out_ff <= '0;
         casc_ff <= '0;
      end else if (out_tick) begin
         out_ff <= rd_value;
         casc_ff <= casc_word;
      end
   end

   // bypass trades a cycle of latency for a half-cycle path from the array
   assign o_q = bypass ? rd_value : out_ff;
   // oldest tap leaves here to feed the next block's write data
   assign o_cascade = bypass ? casc_word : casc_ff;

endmodule
`default_nettype wire
